// *** port_mirror_map.vh ***
// Register offsets, field positions and reset values of the mirror unit.
`ifndef PORT_MIRROR_MAP_VH
`define PORT_MIRROR_MAP_VH

// ==========================================================
// Register byte offsets
`define PM_OFS_CONFIG 4'h0
`define PM_OFS_STATUS 4'h4

// ==========================================================
// Mirror configuration register fields
`define PM_CFG_WIDTH 15
`define PM_CFG_SEL_MSB 11
`define PM_CFG_REMOTE_BIT 12
`define PM_CFG_RXDIR_BIT 13
`define PM_CFG_PORT0_BIT 14
`define PM_CFG_RESET 15'h0000

// ==========================================================
// Status register fields
`define PM_STS_OVF_BIT 0
`define PM_STS_EMPTY_BIT 1
`define PM_STS_FULL_BIT 2
`define PM_STS_LVL_LSB 4
`define PM_STS_LVL_MSB 7

// ==========================================================
// Bus handshake reset values
`define PM_WAIT_RESET 1'b1
`define PM_RDATA_RESET 32'h0000_0000

`endif

// *** mirror_fifo.v ***
// Flip-flop FIFO with valid/ready handshake on both sides.
`timescale 1ns/1ps
`default_nettype none

module mirror_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clock_in,
   input wire resetn_in,
   input wire [WIDTH-1:0] in_data_in,
   input wire in_valid_in,
   output wire in_ready_out,
   output wire [WIDTH-1:0] out_data_out,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [AW:0] level_out
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW:0] wr_ptr_r;
   reg [AW:0] rd_ptr_r;
   wire full;
   wire empty;
   wire push;
   wire pop;

   assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                 (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];
   assign push = in_valid_in & ~full;
   assign pop = out_ready_in & ~empty;
   assign level_out = wr_ptr_r - rd_ptr_r;

   // The storage itself needs no reset; only the pointers define state.
   always @(posedge clock_in) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
      end
   end

   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr_r <= {(AW+1){1'b0}};
         rd_ptr_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// *** port_mirror_select.v ***
// Port mirroring unit: source selection, inter-chip path and mirror output.
//
// Summary of operation
// - Copy receive or transmit traffic of any one local port to the mirror.
// - Mirror output is port 0 or a dedicated MII port fed by data out.
// - Port 0 chosen as mirror output stops carrying its own traffic.
// - Accept peer mirror traffic on two bits qualified by a data enable.
// - Send mirror traffic to the peer on two bits with a data enable.
// - Config bits 11..0 pick the mirrored local port, one bit per port.
// - Config bit 12 marks the mirrored port remote; remote forces 11..0 zero.
// - Config bit 13 picks direction: 0 transmit, 1 receive.
// - Direction bit counts only on the chip holding the mirrored port.
// - Config bit 14 makes port 0 the mirror output, else ordinary port.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "port_mirror_map.vh"

module port_mirror_select #(
   parameter NUM_PORTS = 12,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire clock_in,
   input wire resetn_in,
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output wire [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   input wire [2*NUM_PORTS-1:0] port_rx_data_in,
   input wire [NUM_PORTS-1:0] port_rx_valid_in,
   input wire [2*NUM_PORTS-1:0] port_tx_data_in,
   input wire [NUM_PORTS-1:0] port_tx_valid_in,
   input wire port0_ready_in,
   output wire [1:0] port0_tx_data_out,
   output wire port0_tx_valid_out,
   output wire port0_normal_stop_out,
   output wire mirror_accept_out,
   input wire [1:0] mirror_data_in,
   input wire mirror_data_valid_in,
   output wire [1:0] mirror_data_out,
   output wire mirror_data_valid_out
);

   // ==========================================================
   // Register state
   reg [`PM_CFG_WIDTH-1:0] mirror_config_reg;
   reg [`PM_CFG_WIDTH-1:0] cfg_nxt;
   reg overflow_r;
   reg wait_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;
   reg [1:0] port0_data_r;
   reg port0_valid_r;
   reg port0_stop_r;
   reg accept_r;
   reg [1:0] peer_data_r;
   reg peer_valid_r;

   wire [NUM_PORTS-1:0] sel;
   wire cfg_remote;
   wire cfg_rxdir;
   wire cfg_port0;
   wire bus_req;
   wire wr_fire;
   wire rd_take;
   wire cfg_hit;
   wire sts_hit;
   wire ovf_clear;
   wire slice_lost;

   assign sel = mirror_config_reg[`PM_CFG_SEL_MSB:0];
   assign cfg_remote = mirror_config_reg[`PM_CFG_REMOTE_BIT];
   assign cfg_rxdir = mirror_config_reg[`PM_CFG_RXDIR_BIT];
   assign cfg_port0 = mirror_config_reg[`PM_CFG_PORT0_BIT];

   // ==========================================================
   // Peer input synchroniser
   // The peer chip's pins are treated as asynchronous, so data and enable
   // each pass two flip-flops before the selection logic sees them.
   // The two extra cycles cost nothing: the peer stream has no
   // back-pressure, and the FIFO depth is sized for port 0 stalls.
   reg [2:0] peer_meta_r;
   reg [2:0] peer_sync_r;

   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         peer_meta_r <= 3'h0;
         peer_sync_r <= 3'h0;
      end else begin
         peer_meta_r <= {mirror_data_valid_in, mirror_data_in};
         peer_sync_r <= peer_meta_r;
      end
   end

   // ==========================================================
   // Local port selection
   // A one-hot selection is expected; if software sets several bits the
   // lowest-numbered port wins rather than merging streams.
   wire [NUM_PORTS:0] taken;
   wire [NUM_PORTS-1:0] pick_valid;
   wire [2*NUM_PORTS-1:0] pick_data;

   assign taken[0] = 1'b0;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
         wire hit;
         wire [1:0] slice;
         wire slice_valid;
         assign hit = sel[gi] & ~taken[gi];
         assign taken[gi+1] = taken[gi] | sel[gi];
         assign slice = cfg_rxdir ? port_rx_data_in[2*gi+1:2*gi] :
                        port_tx_data_in[2*gi+1:2*gi];
         assign slice_valid = cfg_rxdir ? port_rx_valid_in[gi] :
                              port_tx_valid_in[gi];
         assign pick_valid[gi] = hit & slice_valid;
         assign pick_data[2*gi+1:2*gi] = {2{hit}} & slice;
      end
   endgenerate

   reg [1:0] local_data;
   integer k;

   always @* begin
      local_data = 2'h0;
      for (k = 0; k < NUM_PORTS; k = k + 1) begin
         local_data = local_data | pick_data[2*k +: 2];
      end
   end

   // ==========================================================
   // Source choice and FIFO
   // On the remote side the direction bit plays no part: the peer chip
   // already chose what it sends.
   wire [1:0] src_data;
   wire src_valid;
   wire fifo_in_ready;
   wire [1:0] fifo_data;
   wire fifo_valid;
   wire fifo_out_ready;
   wire [FIFO_AW:0] fifo_level;
   wire fifo_pop;

   assign src_data = cfg_remote ? peer_sync_r[1:0] : local_data;
   assign src_valid = cfg_remote ? peer_sync_r[2] :
                      (|pick_valid);
   // Port 0 may stall the drain; the peer link and MII port cannot.
   assign fifo_out_ready = cfg_port0 ? port0_ready_in : 1'b1;
   assign fifo_pop = fifo_valid & fifo_out_ready;
   // A slice that meets a full FIFO is lost; software learns of it from
   // the sticky overflow flag, since the sources cannot be held back.
   assign slice_lost = src_valid & ~fifo_in_ready;
   // Eight slots ride out a short port 0 stall; a longer one overflows.

   mirror_fifo #(
      .WIDTH(2),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .in_data_in(src_data),
      .in_valid_in(src_valid),
      .in_ready_out(fifo_in_ready),
      .out_data_out(fifo_data),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_out_ready),
      .level_out(fifo_level)
   );

   // ==========================================================
   // Mirror outputs
   // Mirrored slices leave in order, one per enabled cycle; the data lines
   // are held at zero whenever the enable is low.
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         peer_data_r <= 2'h0;
         peer_valid_r <= 1'b0;
         port0_data_r <= 2'h0;
         port0_valid_r <= 1'b0;
         port0_stop_r <= 1'b0;
         accept_r <= 1'b0;
      end else begin
         accept_r <= fifo_in_ready;
         port0_stop_r <= cfg_port0;
         // Only the chip that holds the mirrored port feeds the peer/MII path.
         if (fifo_pop && !cfg_remote) begin
            peer_data_r <= fifo_data;
            peer_valid_r <= 1'b1;
         end else begin
            peer_data_r <= 2'h0;
            peer_valid_r <= 1'b0;
         end
         if (cfg_port0) begin
            port0_data_r <= fifo_pop ? fifo_data : 2'h0;
            port0_valid_r <= fifo_pop;
         end else begin
            // Outside mirror mode port 0 carries its own transmit stream,
            // registered like the mirror output stage: one cycle late, where mirrored local slices take two.
            port0_data_r <= port_tx_data_in[1:0];
            port0_valid_r <= port_tx_valid_in[0];
         end
      end
   end

   assign mirror_data_out = peer_data_r;
   assign mirror_data_valid_out = peer_valid_r;
   assign port0_tx_data_out = port0_data_r;
   assign port0_tx_valid_out = port0_valid_r;
   assign port0_normal_stop_out = port0_stop_r;
   assign mirror_accept_out = accept_r;

   // ==========================================================
   // Avalon-MM slave
   // Every access is answered with exactly one wait state: waitrequest is
   // high in the first cycle of a request and low in the second.
   assign bus_req = avs_read_in | avs_write_in;
   assign wr_fire = avs_write_in & ~wait_r;
   assign rd_take = avs_read_in & wait_r;
   assign cfg_hit = (avs_address_in == `PM_OFS_CONFIG);
   assign sts_hit = (avs_address_in == `PM_OFS_STATUS);
   // Clearing needs a one in the flag's own bit, so a careless write of
   // zeros to the status word never hides an overflow.
   assign ovf_clear = wr_fire & sts_hit & avs_byteenable_in[0] &
                      avs_writedata_in[`PM_STS_OVF_BIT];

   // ==========================================================
   // Register write decode
   always @* begin
      cfg_nxt = mirror_config_reg;
      if (wr_fire && cfg_hit) begin
         if (avs_byteenable_in[0]) begin
            cfg_nxt[7:0] = avs_writedata_in[7:0];
         end
         if (avs_byteenable_in[1]) begin
            cfg_nxt[`PM_CFG_WIDTH-1:8] =
               avs_writedata_in[`PM_CFG_WIDTH-1:8];
         end
         // A chip marked remote holds no local selection; clearing it here
         // rather than masking it at each use keeps readback truthful.
         if (cfg_nxt[`PM_CFG_REMOTE_BIT]) begin
            cfg_nxt[`PM_CFG_SEL_MSB:0] = 12'h000;
         end
      end
   end

   // ==========================================================
   // Register read mux
   // Read data are captured in the wait cycle so that they stand settled
   // in the cycle in which waitrequest is low.
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address_in)
         `PM_OFS_CONFIG: begin
            rdata_nxt[`PM_CFG_WIDTH-1:0] = mirror_config_reg;
         end
         `PM_OFS_STATUS: begin
            rdata_nxt[`PM_STS_OVF_BIT] = overflow_r;
            rdata_nxt[`PM_STS_EMPTY_BIT] = ~fifo_valid;
            rdata_nxt[`PM_STS_FULL_BIT] = ~fifo_in_ready;
            rdata_nxt[`PM_STS_LVL_MSB:`PM_STS_LVL_LSB] = fifo_level;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // Register updates
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wait_r <= `PM_WAIT_RESET;
         rdata_r <= `PM_RDATA_RESET;
         mirror_config_reg <= `PM_CFG_RESET;
         overflow_r <= 1'b0;
      end else begin
         wait_r <= ~(bus_req & wait_r);
         if (rd_take) begin
            rdata_r <= rdata_nxt;
         end
         mirror_config_reg <= cfg_nxt;
         // A slice lost to a full FIFO sets the flag; set beats clear.
         if (slice_lost) begin
            overflow_r <= 1'b1;
         end else if (ovf_clear) begin
            overflow_r <= 1'b0;
         end
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;

endmodule

`default_nettype wire

// *** port_mirror_select_sva.sv ***
// Concurrent checks on the ports of the port mirroring unit.
`timescale 1ns/1ps
`default_nettype none
module port_mirror_select_sva (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic port0_normal_stop_out,
   input wire logic mirror_accept_out,
   input wire logic [1:0] mirror_data_out,
   input wire logic mirror_data_valid_out
);
   // ==========================================================
   // Bus handshake
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   wait_ack_a: assert property ((avs_read_in || avs_write_in) &&
      avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no ack");
   wait_single_a: assert property (!avs_waitrequest_out |=>
      avs_waitrequest_out) else $error("ack longer than one cycle");
   rdata_hold_a: assert property (!(avs_read_in && avs_waitrequest_out) |=>
      $stable(avs_readdata_out)) else $error("read data moved");
   unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out &&
      avs_address_in != 4'h0 && avs_address_in != 4'h4 |->
      avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   // ==========================================================
   // Configuration and mirror path
   cfg_field_a: assert property (
      avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0 |->
      avs_readdata_out[31:15] == 17'h0 && (!avs_readdata_out[12] ||
      avs_readdata_out[11:0] == 12'h0)) else $error("bad config fields");
   stop_follow_a: assert property (
      avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0 |->
      ##2 port0_normal_stop_out == $past(avs_writedata_in[14], 2))
      else $error("port0 stop does not follow config");
   mirror_quiet_a: assert property (!mirror_data_valid_out |->
      mirror_data_out == 2'b00) else $error("mirror data while idle");
   accept_up_a: assert property ($rose(resetn_in) |=>
      mirror_accept_out) else $error("not accepting after reset");
endmodule
bind port_mirror_select port_mirror_select_sva u_sva (
   .clock_in(clock_in), .resetn_in(resetn_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .port0_normal_stop_out(port0_normal_stop_out),
   .mirror_accept_out(mirror_accept_out),
   .mirror_data_out(mirror_data_out),
   .mirror_data_valid_out(mirror_data_valid_out));
`default_nettype wire

// *** mirror_peer_model.sv ***
// Paired chip model that sends one byte as four enabled two-bit slices.
`timescale 1ns/1ps
`default_nettype none
module mirror_peer_model (
   input wire logic clock_in,
   input wire logic start_in,
   input wire logic [7:0] byte_in,
   output logic [1:0] data_out,
   output logic valid_out
);
   logic [7:0] shift_r;
   int n = 0;
   initial begin
      data_out = 2'b00;
      valid_out = 1'b0;
   end
   // Idle data toggles so a receiver that ignores the enable is caught.
   always @(posedge clock_in) begin
      if (start_in && n == 0) begin
         shift_r <= byte_in >> 2;
         data_out <= byte_in[1:0];
         valid_out <= 1'b1;
         n <= 3;
      end else if (n > 0) begin
         data_out <= shift_r[1:0];
         shift_r <= shift_r >> 2;
         n <= n - 1;
      end else begin
         valid_out <= 1'b0;
         data_out <= ~data_out;
      end
   end
endmodule
`default_nettype wire

// *** port_mirror_select_test.sv ***
// Self-checking bench for the port mirroring unit.
`timescale 1ns/1ps
`default_nettype none
module port_mirror_select_test;
   logic clk, rst_n, rd, wr, rdy, start, feed, cap, p0, dir;
   logic [3:0] adr;
   logic [31:0] wd, rdat, r;
   logic [23:0] rxd, txd;
   logic [11:0] rxv, txv;
   logic [1:0] p0d, md, pd, e, td0;
   logic p0v, stop, mv, pv, wt, tv0, rq;
   logic [7:0] pb, b;
   logic [1:0] q[$];
   int n_fail = 0, checked = 0, p, pn;
   port_mirror_select u_port_mirror_select (.clock_in(clk),
      .resetn_in(rst_n), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
      .port_rx_data_in(rxd), .port_rx_valid_in(rxv), .port_tx_data_in(txd),
      .port_tx_valid_in(txv), .port0_ready_in(rdy), .port0_tx_data_out(p0d),
      .port0_tx_valid_out(p0v), .port0_normal_stop_out(stop),
      .mirror_accept_out(), .mirror_data_in(pd), .mirror_data_valid_in(pv),
      .mirror_data_out(md), .mirror_data_valid_out(mv));
   mirror_peer_model u_mirror_peer_model (.clock_in(clk), .start_in(start),
      .byte_in(pb), .data_out(pd), .valid_out(pv));
   // ==========================================================
   // Tasks
   task check(input string s, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task complete_run;
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 50);
      if (n == 50) check("ack", 0, 1);
      r = rdat;
      rd <= 0;
      wr <= 0;
      @(posedge clk);
   endtask
   task rchk(input string s, input logic [3:0] a, input logic [31:0] x);
      bus(0, a, 0);
      check(s, r, x);
   endtask
   // ==========================================================
   // Clock, stimulus and reference model
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      n_fail++;
      complete_run;
   end
   // A full FIFO with a stalled drain drops slices, so the model caps at 8.
   always @(posedge clk) begin
      if ((dir ? rxv[p] : txv[p]) && (!cap || q.size() < 8))
         q.push_back(dir ? rxd[2*p+:2] : txd[2*p+:2]);
      rxd <= $urandom;
      txd <= $urandom;
      rxv <= feed ? $urandom : 0;
      txv <= feed ? $urandom : 0;
   end
   always @(posedge clk) if (rst_n && (p0 ? p0v && rdy : mv) === 1'b1) begin
      e = q.size() ? q.pop_front() : 2'bxx;
      check("slice", p0 ? p0d : md, e);
   end
   // Outside mirror mode port 0 forwards its own transmit lane a cycle late.
   always @(posedge clk) begin
      td0 <= txd[1:0];
      tv0 <= txv[0];
      rq <= rst_n;
      if (rq && !p0) check("port0", {p0v, p0d}, {tv0, td0});
   end
   // ==========================================================
   // Scenarios
   initial begin
      rst_n = 0; rd = 0; wr = 0; adr = 0; wd = 0; rdy = 1; start = 0;
      pb = 0; feed = 0; cap = 0; p0 = 0; dir = 0; p = 0;
      rxd = 0; txd = 0; rxv = 0; txv = 0;
      r = $urandom(83);
      repeat (20) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rchk("cfg", 4'h0, 0);
      rchk("sts", 4'h4, 32'h2);
      bus(1, 4'h8, 32'h3);
      rchk("gap", 4'h8, 0);
      bus(1, 4'h0, 32'h1fff);
      rchk("remote", 4'h0, 32'h1000);
      for (int k = 0; k < 3; k++) begin
         pn = $urandom_range(11);
         p <= pn;
         dir <= k[0];
         p0 <= k[1];
         cap <= k[1];
         rdy <= !k[1];
         bus(1, 0, (k << 13) | (1 << pn));
         @(posedge clk);
         check("stop", stop, p0);
         rchk("cfg", 0, (k << 13) | (1 << p));
         feed <= 1;
         repeat (40) @(posedge clk);
         feed <= 0;
         if (p0) begin
            repeat (4) @(posedge clk);
            rchk("ovf", 4'h4, 32'h85);
            bus(1, 4'h4, 1);
            rchk("w1c", 4'h4, 32'h84);
            cap <= 0;
            rdy <= 1;
         end
         repeat (20) @(posedge clk);
         check("left", q.size(), 0);
         rchk("drain", 4'h4, 32'h2);
      end
      for (int k = 0; k < 2; k++) begin
         bus(1, 0, 32'h5000 | (k << 13));
         repeat (3) begin
            b = $urandom;
            pb <= b;
            start <= 1;
            for (int i = 0; i < 4; i++) q.push_back(b[2*i+:2]);
            @(posedge clk);
            start <= 0;
            repeat (5) @(posedge clk);
         end
         repeat (20) @(posedge clk);
         check("peer", q.size(), 0);
      end
      bus(1, 0, 0);
      @(posedge clk);
      check("stop", stop, 0);
      complete_run;
   end
endmodule
`default_nettype wire
